// File: fbc_core.sv
// Four-bit core instruction decode and execute
// Contract
// - Add memory nibble into register, or immediate into memory nibble.
// - Add with carry includes carry flag; register and immediate forms.
// - Subtract memory from register, or immediate from memory nibble.
// - Subtract with borrow also subtracts carry flag; both forms.
// - OR, AND, XOR of register with memory; top bit selects immediate form.
// - Sub-code 1001 increments address register, 1000 increments index register.
// - Bit tests clear compare flag; skip when masked bits all one or zero.
// - Immediate subtract without store; skip on zero or non-zero.
// - Immediate compare; skip on no borrow or on borrow.
// - Table read pushes PC, fetches word at address register into buffer, pops.
// - Push decrements pointer then stores; pop restores then increments.
// - Register-file load and store through window register, addressed by row and low nibble.
// - Peripheral read and write move data buffer; address split 3 and 4.
// - Indirect call pushes PC and jumps to address register; branch only jumps.
// - Direct call pushes PC, loads 11 bits, page forced zero.
// - Direct branch loads 11 bits, page from opcode low bits, limited.
// - Exit pops PC, increments pointer; exit-and-skip also skips one.
// - Interrupt exit restores saved state; irq on and off set enable.
// - Stack entry is always the one selected by the stack pointer.
// - Memory operands use row and column; low nibble is register, immediate, mask.
`timescale 1ns/100ps
`default_nettype none
`include "fbc_regs.svh"
module fbc_core import fbc_pkg::*; #(
   parameter int unsigned STACK_DEPTH = 5,
   parameter int unsigned PAGES = 4,
   parameter logic [12:0] IRQ_VECTOR = 13'h0001
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   output logic [12:0] pmem_addr_out,
   input wire logic [15:0] pmem_data_in,
   output var fbc_nib_req_t dmem_out,
   input wire logic [3:0] dmem_rdata_in,
   input wire logic [2:0] reg_row_in,
   output var fbc_nib_req_t rf_out,
   input wire logic [3:0] rf_rdata_in,
   output var fbc_per_req_t per_out,
   input wire logic [15:0] per_rdata_in,
   input wire logic irq_req_in,
   output logic irq_ack_out,
   input wire logic [3:0] wake_in,
   output logic halt_out,
   output logic stop_out,
   output logic [3:0] release_cond_out,
   output var fbc_view_t status_out
);
   if (STACK_DEPTH < 1 || STACK_DEPTH > 7) begin : g_bad_depth
      $error("STACK_DEPTH must lie in 1..7");
   end
   if (PAGES != 1 && PAGES != 2 && PAGES != 4) begin : g_bad_pages
      $error("PAGES must be 1, 2 or 4");
   end

   localparam logic [2:0] SP_RST = 3'(STACK_DEPTH);
   localparam logic [1:0] PAGE_MASK = 2'(PAGES - 1);

   function automatic fbc_core_t core_rst();
      core_rst = '0;
      core_rst.st = ST_FETCH;
      core_rst.v.pc = `FBC_RST_PC;
      core_rst.v.sp = SP_RST;
   endfunction
   localparam fbc_core_t CORE_RST = core_rst();

   // Data memory address from row and column fields
   function automatic logic [6:0] mem_addr(input logic [15:0] w);
      mem_addr = {w[`FBC_F_ROW], w[`FBC_F_COL]};
   endfunction
   function automatic logic alu_op(input logic [4:0] op);
      alu_op = !op[3] && (op[2:0] != 3'h7);
   endfunction
   function automatic logic reads_reg(input logic [4:0] op);
      reads_reg = (op[4:3] == 2'b00 && op != `FBC_OP_SYS) || op == `FBC_OP_ST ||
                  op == `FBC_OP_MOVIND || op == `FBC_OP_MOVMEM;
   endfunction

   fbc_core_t s;
   fbc_core_t n;
   fbc_alu_t alu;
   logic [15:0] cur;
   logic [4:0] opc;
   logic [3:0] sub;
   logic [2:0] row;
   logic [4:0] iop;
   logic [2:0] sp_m1;
   logic [12:0] pc_inc;
   logic [12:0] top_pc;
   logic [2:0] alu_fn;
   logic [3:0] alu_a;
   logic [3:0] alu_b;
   logic skip_hit;
   logic [4:0] sub_borrow_ref;

   // In decode the word is still on the bus, later it sits in ir
   assign cur = (s.st == ST_DEC) ? pmem_data_in : s.ir;
   assign opc = cur[`FBC_F_OP];
   assign sub = cur[`FBC_F_COL];
   assign row = cur[`FBC_F_ROW];
   assign iop = s.ir[`FBC_F_OP];
   assign sp_m1 = s.v.sp - 3'h1;
   assign pc_inc = s.v.pc + 13'h0001;
   assign top_pc = s.stk[s.v.sp][12:0];

   // Register forms take r op m, the others m op immediate
   assign alu_fn = alu_op(iop) ? iop[2:0] : `FBC_FN_SUB;
   assign alu_a = (iop[4:3] == 2'b00) ? s.rval : s.mval;
   assign alu_b = (iop[4:3] == 2'b00) ? s.mval : s.ir[`FBC_F_LOW];

   fbc_alu u_alu (
      .fn_in(alu_fn),
      .a_in(alu_a),
      .b_in(alu_b),
      .ci_in(s.v.cy),
      .alu_out(alu)
   );

   assign skip_hit = (s.st == ST_EXEC) && (
      (iop == `FBC_OP_SKE && alu.zero) ||
      (iop == `FBC_OP_SKIP_NOT_EQUAL && !alu.zero) ||
      (iop == `FBC_OP_SKIP_NO_BORROW && !alu.co) ||
      (iop == `FBC_OP_SKIP_ON_BORROW && alu.co) ||
      (iop == `FBC_OP_SKT && (s.mval & s.ir[3:0]) == s.ir[3:0]) ||
      (iop == `FBC_OP_SKF && (s.mval & s.ir[3:0]) == 4'h0));

   always_comb begin
      n = s;
      n.dm.we = 1'b0;
      n.rf.we = 1'b0;
      n.pr.we = 1'b0;
      n.pr.re = 1'b0;
      n.irq_ack = 1'b0;
      n.wk1 = wake_in;
      n.wk2 = s.wk1;
      case (s.st)
         ST_FETCH: begin
            if (s.v.ie && irq_req_in) begin
               // Interrupt entry saves PC and flags, then refetches
               n.v.sp = sp_m1;
               n.stk[sp_m1] = {3'h0, s.v.pc};
               n.isk = {s.v.cy, s.v.cmp};
               n.v.ie = 1'b0;
               n.v.pc = IRQ_VECTOR;
               n.irq_ack = 1'b1;
            end else begin
               n.pm_addr = s.v.pc;
               n.st = ST_DEC;
            end
         end
         ST_DEC: begin
            n.ir = cur;
            n.v.pc = pc_inc;
            n.dm.addr = mem_addr(cur);
            n.st = ST_OPA;
            if (opc == `FBC_OP_SYS) begin
               n.st = ST_FETCH;
               case (sub)
                  `FBC_SUB_TBL: begin
                     n.v.sp = sp_m1;
                     n.stk[sp_m1] = {3'h0, pc_inc};
                     n.v.pc = s.v.ar[12:0];
                     n.pm_addr = s.v.ar[12:0];
                     n.st = ST_TBL;
                  end
                  `FBC_SUB_REGFILE_STORE: begin
                     n.rf.addr = {row, cur[`FBC_F_LOW]};
                     n.rf.wdata = s.v.wr;
                     n.rf.we = 1'b1;
                  end
                  `FBC_SUB_REGFILE_LOAD: begin
                     n.rf.addr = {row, cur[`FBC_F_LOW]};
                     n.st = ST_EXEC;
                  end
                  `FBC_SUB_BRA: n.v.pc = s.v.ar[12:0];
                  `FBC_SUB_CALLA: begin
                     n.v.sp = sp_m1;
                     n.stk[sp_m1] = {3'h0, pc_inc};
                     n.v.pc = s.v.ar[12:0];
                  end
                  `FBC_SUB_ROTATE_RIGHT_CARRY: begin
                     n.dm.addr = {reg_row_in, cur[`FBC_F_LOW]};
                     n.st = ST_OPA;
                  end
                  `FBC_SUB_INCIX: n.v.ix = s.v.ix + 12'h001;
                  `FBC_SUB_INCAR: n.v.ar = s.v.ar + 16'h0001;
                  `FBC_SUB_PUT: begin
                     n.pr.addr = {row, cur[`FBC_F_LOW]};
                     n.pr.wdata = s.v.dbf;
                     n.pr.we = 1'b1;
                  end
                  `FBC_SUB_GET: begin
                     n.pr.addr = {row, cur[`FBC_F_LOW]};
                     n.pr.re = 1'b1;
                     n.st = ST_EXEC;
                  end
                  `FBC_SUB_POP: begin
                     n.v.ar = s.stk[s.v.sp];
                     n.v.sp = s.v.sp + 3'h1;
                  end
                  `FBC_SUB_PUSH: begin
                     n.v.sp = sp_m1;
                     n.stk[sp_m1] = s.v.ar;
                  end
                  `FBC_SUB_EXIT: begin
                     n.v.pc = top_pc;
                     n.v.sp = s.v.sp + 3'h1;
                     if (row == `FBC_ROW_EXSK) begin
                        n.v.pc = top_pc + 13'h0001;
                     end
                     if (row == `FBC_ROW_IRET) begin
                        {n.v.cy, n.v.cmp} = s.isk;
                     end
                  end
                  `FBC_SUB_MISC: begin
                     case (row)
                        `FBC_ROW_IRQON: n.v.ie = 1'b1;
                        `FBC_ROW_IRQOFF: n.v.ie = 1'b0;
                        `FBC_ROW_STOP: begin
                           n.stop = 1'b1;
                           n.cond = cur[`FBC_F_LOW];
                           n.st = ST_WAIT;
                        end
                        `FBC_ROW_HALT: begin
                           n.halt = 1'b1;
                           n.cond = cur[`FBC_F_LOW];
                           n.st = ST_WAIT;
                        end
                        default: n.st = ST_FETCH;
                     endcase
                  end
                  default: n.st = ST_FETCH;
               endcase
            end else if (opc[4:2] == `FBC_BR_HI) begin
               n.v.pc = {opc[1:0] & PAGE_MASK, cur[`FBC_F_ADDR]};
               n.st = ST_FETCH;
            end else if (opc == `FBC_OP_CALL) begin
               n.v.sp = sp_m1;
               n.stk[sp_m1] = {3'h0, pc_inc};
               n.v.pc = {2'b00, cur[`FBC_F_ADDR]};
               n.st = ST_FETCH;
            end
         end
         ST_OPA: begin
            n.mval = dmem_rdata_in;
            n.st = ST_EXEC;
            if (reads_reg(iop)) begin
               n.dm.addr = {reg_row_in, s.ir[`FBC_F_LOW]};
               n.st = ST_OPB;
            end
         end
         ST_OPB: begin
            n.rval = dmem_rdata_in;
            n.st = ST_EXEC;
            if (iop == `FBC_OP_MOVIND) begin
               // Register holds the column within the operand row
               n.dm.addr = {s.ir[`FBC_F_ROW], dmem_rdata_in};
               n.dm.wdata = s.mval;
               n.dm.we = 1'b1;
               n.st = ST_FETCH;
            end else if (iop == `FBC_OP_MOVMEM) begin
               n.dm.addr = {s.ir[`FBC_F_ROW], dmem_rdata_in};
               n.st = ST_IND;
            end
         end
         ST_IND: begin
            n.rval = dmem_rdata_in;
            n.st = ST_EXEC;
         end
         ST_EXEC: begin
            n.st = ST_FETCH;
            if (skip_hit) begin
               n.v.pc = pc_inc;
            end
            case (iop)
               `FBC_OP_LD: begin
                  n.dm.addr = {reg_row_in, s.ir[`FBC_F_LOW]};
                  n.dm.wdata = s.mval;
                  n.dm.we = 1'b1;
               end
               `FBC_OP_ST, `FBC_OP_MOVMEM: begin
                  n.dm.addr = mem_addr(s.ir);
                  n.dm.wdata = s.rval;
                  n.dm.we = 1'b1;
               end
               `FBC_OP_MOVI: begin
                  n.dm.addr = mem_addr(s.ir);
                  n.dm.wdata = s.ir[`FBC_F_LOW];
                  n.dm.we = 1'b1;
               end
               `FBC_OP_SKT, `FBC_OP_SKF: n.v.cmp = 1'b0;
               `FBC_OP_SYS: begin
                  case (s.ir[`FBC_F_COL])
                     `FBC_SUB_ROTATE_RIGHT_CARRY: begin
                        n.dm.addr = {reg_row_in, s.ir[`FBC_F_LOW]};
                        n.dm.wdata = {s.v.cy, s.mval[3:1]};
                        n.dm.we = 1'b1;
                        n.v.cy = s.mval[0];
                     end
                     `FBC_SUB_GET: n.v.dbf = per_rdata_in;
                     `FBC_SUB_REGFILE_LOAD: n.v.wr = rf_rdata_in;
                     default: n.st = ST_FETCH;
                  endcase
               end
               default: begin
                  if (alu_op(iop)) begin
                     // Register form writes r, immediate form writes m
                     n.dm.addr = iop[4] ? mem_addr(s.ir) : {reg_row_in, s.ir[`FBC_F_LOW]};
                     n.dm.wdata = alu.res;
                     n.dm.we = 1'b1;
                     if (!iop[2]) begin
                        n.v.cy = alu.co;
                     end
                  end
               end
            endcase
         end
         ST_TBL: begin
            n.v.dbf = pmem_data_in;
            n.v.pc = top_pc;
            n.v.sp = s.v.sp + 3'h1;
            n.st = ST_FETCH;
         end
         ST_WAIT: begin
            if ((s.wk2 & s.cond) != 4'h0) begin
               n.halt = 1'b0;
               n.stop = 1'b0;
               n.st = ST_FETCH;
            end
         end
         default: n.st = ST_FETCH;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s <= CORE_RST;
      end else begin
         s <= n;
      end
   end

   assign pmem_addr_out = s.pm_addr;
   assign dmem_out = s.dm;
   assign rf_out = s.rf;
   assign per_out = s.pr;
   assign irq_ack_out = s.irq_ack;
   assign halt_out = s.halt;
   assign stop_out = s.stop;
   assign release_cond_out = s.cond;
   assign status_out = s.v;

   assign sub_borrow_ref = {1'b0, s.rval} - {1'b0, s.mval} - {4'h0, s.v.cy};

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_tbl_start;
      s.st == ST_DEC && opc == `FBC_OP_SYS && sub == `FBC_SUB_TBL;
   endsequence
   sequence s_tbl_fetch;
      s.st == ST_TBL && s.pm_addr == $past(s.v.ar[12:0]);
   endsequence

   a_table_read_seq: assert property (s_tbl_start |=> s_tbl_fetch ##1
      (s.v.dbf == $past(pmem_data_in) && s.v.sp == $past(s.v.sp, 2) && s.v.pc == $past(s.v.pc, 2) + 13'h0001))
      else $error("table read sequence wrong");
   a_add_reg_write: assert property ((s.st == ST_EXEC && iop == `FBC_OP_ADD) |=>
      (s.dm.we && s.dm.wdata == 4'($past(s.rval) + $past(s.mval))))
      else $error("register add result wrong");
   a_sub_borrow_carry: assert property ((s.st == ST_EXEC && iop == `FBC_OP_SUB_BORROW) |=>
      (s.v.cy == $past(sub_borrow_ref[4]) && s.dm.wdata == $past(sub_borrow_ref[3:0])))
      else $error("subtract with borrow wrong");
   a_skip_equal_pc: assert property ((s.st == ST_EXEC && iop == `FBC_OP_SKE && s.mval == s.ir[3:0]) |=>
      (s.v.pc == $past(s.v.pc) + 13'h0001 && !s.dm.we))
      else $error("equal skip not taken");
   a_bit_test_cmp: assert property ((s.st == ST_EXEC && (iop == `FBC_OP_SKT || iop == `FBC_OP_SKF)) |=>
      !s.v.cmp)
      else $error("bit test left compare flag set");
   a_push_entry: assert property ((s.st == ST_DEC && opc == `FBC_OP_SYS && sub == `FBC_SUB_PUSH) |=>
      (s.v.sp == $past(s.v.sp) - 3'h1 && s.stk[s.v.sp] == $past(s.v.ar)))
      else $error("push entry wrong");
   a_call_direct: assert property ((s.st == ST_DEC && opc == `FBC_OP_CALL) |=>
      (s.v.pc == {2'b00, $past(pmem_data_in[10:0])} && s.stk[s.v.sp][12:0] == $past(s.v.pc) + 13'h0001))
      else $error("direct call wrong");
   a_branch_page: assert property ((s.st == ST_DEC && opc[4:2] == `FBC_BR_HI) |=>
      (s.v.pc[10:0] == $past(pmem_data_in[10:0]) && s.v.pc[12:11] == ($past(pmem_data_in[12:11]) & PAGE_MASK)))
      else $error("branch page wrong");
   a_exit_skip_pc: assert property ((s.st == ST_DEC && opc == `FBC_OP_SYS && sub == `FBC_SUB_EXIT &&
      row == `FBC_ROW_EXSK) |=> (s.v.pc == $past(top_pc) + 13'h0001 && s.v.sp == $past(s.v.sp) + 3'h1))
      else $error("exit and skip wrong");
   a_irq_on_flag: assert property ((s.st == ST_DEC && opc == `FBC_OP_SYS && sub == `FBC_SUB_MISC &&
      row == `FBC_ROW_IRQON) |=> s.v.ie)
      else $error("irq enable not set");
endmodule
`default_nettype wire

// File: fbc_regs.svh
// Opcode, sub-code, row-code and field constants for the four-bit core
`ifndef FBC_REGS_SVH
`define FBC_REGS_SVH
`define FBC_F_OP 15:11
`define FBC_F_ROW 10:8
`define FBC_F_COL 7:4
`define FBC_F_LOW 3:0
`define FBC_F_ADDR 10:0
`define FBC_OP_ADD 5'h00
`define FBC_OP_SUB_BORROW 5'h03
`define FBC_OP_SYS 5'h07
`define FBC_OP_LD 5'h08
`define FBC_OP_SKE 5'h09
`define FBC_OP_MOVIND 5'h0A
`define FBC_OP_SKIP_NOT_EQUAL 5'h0B
`define FBC_OP_ST 5'h18
`define FBC_OP_SKIP_NO_BORROW 5'h19
`define FBC_OP_MOVMEM 5'h1A
`define FBC_OP_SKIP_ON_BORROW 5'h1B
`define FBC_OP_CALL 5'h1C
`define FBC_OP_MOVI 5'h1D
`define FBC_OP_SKT 5'h1E
`define FBC_OP_SKF 5'h1F
`define FBC_BR_HI 3'h3
`define FBC_FN_ADD 3'h0
`define FBC_FN_SUB 3'h1
`define FBC_FN_ADD_CARRY 3'h2
`define FBC_FN_SUB_BORROW 3'h3
`define FBC_FN_AND 3'h4
`define FBC_FN_XOR 3'h5
`define FBC_FN_OR 3'h6
`define FBC_SUB_TBL 4'h1
`define FBC_SUB_REGFILE_STORE 4'h2
`define FBC_SUB_REGFILE_LOAD 4'h3
`define FBC_SUB_BRA 4'h4
`define FBC_SUB_CALLA 4'h5
`define FBC_SUB_ROTATE_RIGHT_CARRY 4'h7
`define FBC_SUB_INCIX 4'h8
`define FBC_SUB_INCAR 4'h9
`define FBC_SUB_PUT 4'hA
`define FBC_SUB_GET 4'hB
`define FBC_SUB_POP 4'hC
`define FBC_SUB_PUSH 4'hD
`define FBC_SUB_EXIT 4'hE
`define FBC_SUB_MISC 4'hF
`define FBC_ROW_EXSK 3'h1
`define FBC_ROW_IRET 3'h4
`define FBC_ROW_IRQON 3'h0
`define FBC_ROW_IRQOFF 3'h1
`define FBC_ROW_STOP 3'h2
`define FBC_ROW_HALT 3'h3
`define FBC_RST_PC 13'h0000
`endif

// File: fbc_pkg.sv
// Types shared by the four-bit core and its nibble ALU
package fbc_pkg;
   typedef enum logic [2:0] {ST_FETCH, ST_DEC, ST_OPA, ST_OPB, ST_IND, ST_EXEC, ST_TBL, ST_WAIT} fbc_state_t;
   typedef struct packed {
      logic [6:0] addr;
      logic [3:0] wdata;
      logic we;
   } fbc_nib_req_t;
   typedef struct packed {
      logic [6:0] addr;
      logic [15:0] wdata;
      logic we;
      logic re;
   } fbc_per_req_t;
   typedef struct packed {
      logic [12:0] pc;
      logic [15:0] ar;
      logic [11:0] ix;
      logic [15:0] dbf;
      logic [3:0] wr;
      logic [2:0] sp;
      logic cy;
      logic cmp;
      logic ie;
   } fbc_view_t;
   typedef struct packed {
      logic [3:0] res;
      logic co;
      logic zero;
   } fbc_alu_t;
   typedef struct packed {
      fbc_state_t st;
      logic [15:0] ir;
      fbc_view_t v;
      logic [3:0] mval;
      logic [3:0] rval;
      logic [1:0] isk;
      logic [7:0][15:0] stk;
      logic [12:0] pm_addr;
      fbc_nib_req_t dm;
      fbc_nib_req_t rf;
      fbc_per_req_t pr;
      logic halt;
      logic stop;
      logic [3:0] cond;
      logic irq_ack;
      logic [3:0] wk1;
      logic [3:0] wk2;
   } fbc_core_t;
endpackage

// File: fbc_alu.sv
// Nibble ALU: add, subtract, with carry or borrow, and logic ops
`timescale 1ns/100ps
`default_nettype none
`include "fbc_regs.svh"
module fbc_alu import fbc_pkg::*; (
   input wire logic [2:0] fn_in,
   input wire logic [3:0] a_in,
   input wire logic [3:0] b_in,
   input wire logic ci_in,
   output var fbc_alu_t alu_out
);
   logic [4:0] wide;
   always_comb begin
      wide = 5'h00;
      case (fn_in)
         `FBC_FN_ADD: wide = {1'b0, a_in} + {1'b0, b_in};
         `FBC_FN_ADD_CARRY: wide = {1'b0, a_in} + {1'b0, b_in} + {4'h0, ci_in};
         `FBC_FN_SUB: wide = {1'b0, a_in} - {1'b0, b_in};
         `FBC_FN_SUB_BORROW: wide = {1'b0, a_in} - {1'b0, b_in} - {4'h0, ci_in};
         `FBC_FN_AND: wide = {1'b0, a_in & b_in};
         `FBC_FN_XOR: wide = {1'b0, a_in ^ b_in};
         `FBC_FN_OR: wide = {1'b0, a_in | b_in};
         default: wide = 5'h00;
      endcase
      alu_out.res = wide[3:0];
      alu_out.co = wide[4];
      alu_out.zero = (wide[3:0] == 4'h0);
   end
endmodule
`default_nettype wire

// File: fbc_mem_model.sv
// Program, data, register-file and peripheral memories facing the core
`timescale 1ns/100ps
`default_nettype none
module fbc_mem_model import fbc_pkg::*; (
   input wire logic clk_in,
   input wire logic [12:0] pm_addr_in,
   output logic [15:0] pm_data_out,
   input wire fbc_nib_req_t dm_in,
   output logic [3:0] dm_rdata_out,
   input wire fbc_nib_req_t rf_in,
   output logic [3:0] rf_rdata_out,
   input wire fbc_per_req_t per_in,
   output logic [15:0] per_rdata_out
);
   bit [15:0] pm [8192];
   bit [3:0] dm [128];
   bit [3:0] rf [128];
   bit [15:0] pr [128];
   bit re_q;
   assign pm_data_out = pm[pm_addr_in];
   assign dm_rdata_out = dm[dm_in.addr];
   assign rf_rdata_out = rf[rf_in.addr];
   // Garbage outside the read strobe window
   assign per_rdata_out = (per_in.re | re_q) ? pr[per_in.addr] : ~pr[per_in.addr];
   always @(posedge clk_in) begin
      re_q <= per_in.re;
      if (dm_in.we) dm[dm_in.addr] <= dm_in.wdata;
      if (rf_in.we) rf[rf_in.addr] <= rf_in.wdata;
      if (per_in.we) pr[per_in.addr] <= per_in.wdata;
   end
endmodule
`default_nettype wire

// File: test_four_bit_core_instruction_decoder.sv
// Random program bench for the four-bit core against an instruction model
`timescale 1ns/100ps
`default_nettype none
module test_four_bit_core_instruction_decoder;
   import fbc_pkg::*;
   logic core_clk_in, rstn_in, irq_req_in, halt_out, ia, so;
   logic [2:0] reg_row_in;
   logic [3:0] wake_in, dmr, rfr, rc;
   logic [12:0] pma;
   logic [15:0] pmd, prd;
   fbc_nib_req_t dmq, rfq;
   fbc_per_req_t prq;
   fbc_view_t st;
   int err_count, checks_done, cyc, k, n;
   bit [31:0] seed = 32'h6C76;
   bit [15:0] pm [8192];
   bit [3:0] dm [128];
   bit [3:0] rf [128];
   bit [15:0] pr [128];
   bit [15:0] stk [8];
   bit [12:0] pc;
   bit [15:0] ar, dbf;
   bit [11:0] ix;
   bit [3:0] wr;
   bit [2:0] sp, row;
   bit cy, cmp, ie, h;
   bit [4:0] ops [32] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11, 5'h12, 5'h13,
      5'h14, 5'h15, 5'h16, 5'h08, 5'h18, 5'h1D, 5'h0A, 5'h1A, 5'h09, 5'h0B, 5'h19, 5'h1B, 5'h1E,
      5'h1F, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07};
   bit [3:0] subs [16] = '{4'h9, 4'h8, 4'h1, 4'h3, 4'h2, 4'hB, 4'hA, 4'h7, 4'hF, 4'hD, 4'hC, 4'h9,
      4'h8, 4'h3, 4'hB, 4'h1};
   fbc_core i_fbc_core (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .pmem_addr_out(pma),
      .pmem_data_in(pmd), .dmem_out(dmq), .dmem_rdata_in(dmr), .reg_row_in(reg_row_in), .rf_out(rfq),
      .rf_rdata_in(rfr), .per_out(prq), .per_rdata_in(prd), .irq_req_in(irq_req_in), .irq_ack_out(ia),
      .wake_in(wake_in), .halt_out(halt_out), .stop_out(so), .release_cond_out(rc), .status_out(st));
   fbc_mem_model i_fbc_mem_model (.clk_in(core_clk_in), .pm_addr_in(pma), .pm_data_out(pmd),
      .dm_in(dmq), .dm_rdata_out(dmr), .rf_in(rfq), .rf_rdata_out(rfr), .per_in(prq),
      .per_rdata_out(prd));
   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end
   function automatic bit [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic complete_run();
      if (err_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk_st(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_mem(input logic [3:0] got, input logic [3:0] exp);
      chk_st({12'h0, got}, {12'h0, exp});
   endtask
   task automatic put(input bit [12:0] a, input bit [15:0] w);
      pm[a] = w;
      i_fbc_mem_model.pm[a] = w;
   endtask
   task automatic load(input int k);
      bit [31:0] x;
      bit [12:0] a;
      bit [3:0] u;
      a = {k[1:0], 11'h100};
      x = rnd();
      row = x[2:0];
      for (int i = 0; i < 128; i++) begin
         x = rnd();
         dm[i] = x[3:0];
         rf[i] = x[7:4];
         pr[i] = x[31:16];
         i_fbc_mem_model.dm[i] = x[3:0];
         i_fbc_mem_model.rf[i] = x[7:4];
         i_fbc_mem_model.pr[i] = x[31:16];
      end
      put(13'h0, {5'h1C, 11'h020});
      put(13'h1, {5'h1D, 7'h05, 4'hA});
      put(13'h2, {3'h3, k[1:0], 11'h100});
      put(13'h20, {5'h07, 2'h0, k[0], 8'hE0});
      for (int i = 0; i < 24; i++) begin
         x = rnd();
         u = subs[x[3:0]];
         if (ops[x[31:27]] != 5'h07) put(a + 13'(i), {ops[x[31:27]], x[10:0]});
         else put(a + 13'(i), {5'h07, (u == 4'hF) ? {2'h0, x[8]} : ((u inside {4'h2, 4'h3, 4'hA, 4'hB}) ?
            x[10:8] : 3'h0), u, (u inside {4'h2, 4'h3, 4'h7, 4'hA, 4'hB}) ? x[7:4] : 4'h0});
      end
      put(a + 13'd24, {5'h07, 3'h4, 8'hF0});
      put(a + 13'd25, {5'h07, 3'h3, 8'hF1});
   endtask
   task automatic mstep();
      bit [15:0] w;
      bit [4:0] s;
      bit [3:0] a, b, t;
      bit [6:0] m, r, p;
      bit sk;
      w = pm[pc];
      m = w[10:4];
      r = {row, w[3:0]};
      p = {w[10:8], w[3:0]};
      b = w[3:0];
      a = dm[m];
      pc = pc + 13'h1;
      sk = 1'b0;
      case (w[15:11]) inside
         [5'h00:5'h06], [5'h10:5'h16]: begin
            if (!w[15]) begin
               b = a;
               a = dm[r];
            end
            case (w[13:11])
               3'h0: s = a + b;
               3'h1: s = a - b;
               3'h2: s = a + b + cy;
               3'h3: s = a - b - cy;
               3'h4: s = a & b;
               3'h5: s = a ^ b;
               default: s = a | b;
            endcase
            if (!w[13]) cy = s[4];
            if (w[15]) dm[m] = s[3:0];
            else dm[r] = s[3:0];
         end
         5'h08: dm[r] = dm[m];
         5'h18: dm[m] = dm[r];
         5'h1D: dm[m] = b;
         5'h0A: dm[{w[10:8], dm[r]}] = a;
         5'h1A: dm[m] = dm[{w[10:8], dm[r]}];
         5'h09: sk = (a == b);
         5'h0B: sk = (a != b);
         5'h19: sk = (a >= b);
         5'h1B: sk = (a < b);
         5'h1E, 5'h1F: begin
            cmp = 1'b0;
            sk = w[11] ? ((a & b) == 4'h0) : ((a & b) == b);
         end
         5'h1C: begin
            sp = sp - 3'h1;
            stk[sp] = {3'h0, pc};
            pc = {2'h0, w[10:0]};
         end
         [5'h0C:5'h0F]: pc = w[12:0];
         default: case (w[7:4])
            4'h9: ar = ar + 16'h1;
            4'h8: ix = ix + 12'h1;
            4'h1: begin
               stk[sp - 3'h1] = {3'h0, pc};
               dbf = pm[ar[12:0]];
            end
            4'hD: begin
               sp = sp - 3'h1;
               stk[sp] = ar;
            end
            4'hC: begin
               ar = stk[sp];
               sp = sp + 3'h1;
            end
            4'h3: wr = rf[p];
            4'h2: rf[p] = wr;
            4'hB: dbf = pr[p];
            4'hA: pr[p] = dbf;
            4'hE: begin
               pc = stk[sp][12:0];
               sp = sp + 3'h1;
               sk = (w[10:8] == 3'h1);
            end
            4'h7: begin
               t = dm[r];
               dm[r] = {cy, t[3:1]};
               cy = t[0];
            end
            default: begin
               if (w[10:8] == 3'h0) ie = 1'b1;
               if (w[10:8] == 3'h1) ie = 1'b0;
               h = (w[10:8] == 3'h3);
            end
         endcase
      endcase
      if (sk) pc = pc + 13'h1;
   endtask
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      rstn_in = 1'b0;
      reg_row_in = 3'h0;
      irq_req_in = 1'b0;
      wake_in = 4'h0;
      for (k = 0; k < 8; k++) begin
         load(k);
         @(posedge core_clk_in);
         rstn_in <= 1'b0;
         reg_row_in <= row;
         repeat (12) @(posedge core_clk_in);
         rstn_in <= 1'b1;
         {pc, ar, ix, dbf, wr, cy, cmp, ie, h} = '0;
         sp = 3'h5;
         stk = '{default: 16'h0};
         for (n = 0; n < 200 && !h; n++) mstep();
         for (n = 0; n < 2000 && halt_out !== 1'b1; n++) @(negedge core_clk_in);
         chk_st({3'h0, st.pc}, {3'h0, pc});
         chk_st(st.ar, ar);
         chk_st({4'h0, st.ix}, {4'h0, ix});
         chk_st(st.dbf, dbf);
         chk_mem(st.wr, wr);
         chk_st({13'h0, st.sp}, {13'h0, sp});
         chk_st({14'h0, st.cy, st.cmp}, {14'h0, cy, cmp});
         chk_st({15'h0, st.ie}, {15'h0, ie});
         for (int i = 0; i < 128; i++) begin
            chk_mem(i_fbc_mem_model.dm[i], dm[i]);
            chk_mem(i_fbc_mem_model.rf[i], rf[i]);
            chk_st(i_fbc_mem_model.pr[i], pr[i]);
         end
         chk_st({11'h0, so, rc}, 16'h0001);
         // Release standby with an interrupt pending, then reset mid-run
         @(posedge core_clk_in);
         wake_in <= 4'h1;
         irq_req_in <= 1'b1;
         @(negedge core_clk_in);
         for (n = 0; n < 8 && halt_out === 1'b1; n++) @(negedge core_clk_in);
         @(negedge core_clk_in);
         chk_st({14'h0, ia, halt_out}, {14'h0, ie, 1'b0});
         chk_st({3'h0, st.pc}, ie ? 16'h0001 : {3'h0, pc});
         chk_st({13'h0, st.sp}, {13'h0, sp - {2'h0, ie}});
         @(posedge core_clk_in);
         rstn_in <= 1'b0;
         irq_req_in <= 1'b0;
         wake_in <= 4'h0;
      end
      complete_run();
   end
endmodule
`default_nettype wire
